//--- design/shared_reference_clock_pkg.sv
// shared_reference_clock_pkg: shared constants for the reference clock source and interface select block
// assumes a single 100 MHz core clock and strap levels synchronous to it
package shared_reference_clock_pkg;
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned RMII_REF_HZ   = 50_000_000;
   localparam int unsigned SMII_REF_HZ   = 125_000_000;
   localparam int unsigned XTAL_HZ       = 25_000_000;
   // half period of the model reference clock, in core cycles (50 MHz -> 1 cycle)
   localparam int unsigned RMII_HALF_CYC = CLK_HZ / (2 * RMII_REF_HZ);
   localparam logic [1:0]  HALF_CYC      = 2'(RMII_HALF_CYC);

   // strap levels
   localparam logic SRC_CRYSTAL  = 1'b0;
   localparam logic SRC_EXTERNAL = 1'b1;
   localparam logic FAM_SERIAL   = 1'b0;
   localparam logic FAM_RMII     = 1'b1;

   // interface codes formed from the two select straps
   typedef enum logic [1:0] {
      IFACE_SMII    = 2'b00,
      IFACE_SS_SMII = 2'b01,
      IFACE_RMII    = 2'b10
   } iface_t;

   // reference clock rate codes
   typedef enum logic [1:0] {
      RATE_NONE = 2'b00,
      RATE_50M  = 2'b01,
      RATE_125M = 2'b10
   } rate_t;
endpackage : shared_reference_clock_pkg

//--- design/shared_reference_clock_cfg_if.sv
// shared_reference_clock_cfg_if: carries the latched configuration from the strap latch to the clock mux
// assumes one clock domain; the latch drives, the mux reads
`timescale 1ns/100ps
interface shared_reference_clock_cfg_if;
   logic                  valid;
   logic                  src_external;
   shared_reference_clock_pkg::iface_t    iface;

   modport latch (output valid, output src_external, output iface);
   modport user  (input valid, input src_external, input iface);
endinterface : shared_reference_clock_cfg_if

//--- design/strap_latch.sv
// strap_latch: captures the three configuration straps once after reset release
// assumes straps are static and synchronous to clk_in during the capture cycle
`timescale 1ns/100ps
module strap_latch (
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic iface_select_hi_in,
   input  wire logic iface_select_lo_in,
   input  wire logic clk_source_select_in,
   shared_reference_clock_cfg_if.latch cfg
);
   logic                valid_r;
   logic                src_r;
   shared_reference_clock_pkg::iface_t  iface_r;
   shared_reference_clock_pkg::iface_t  iface_nxt;

   // strap decode: hi strap wins, lo strap only splits the serial family
   assign iface_nxt = (iface_select_hi_in == shared_reference_clock_pkg::FAM_RMII) ? shared_reference_clock_pkg::IFACE_RMII
                    : (iface_select_lo_in ? shared_reference_clock_pkg::IFACE_SS_SMII
                                          : shared_reference_clock_pkg::IFACE_SMII);

   // capture once at the first edge after release, then freeze
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         valid_r <= 1'b0;
         src_r   <= shared_reference_clock_pkg::SRC_CRYSTAL;
         iface_r <= shared_reference_clock_pkg::IFACE_SMII;
      end else if (!valid_r) begin
         valid_r <= 1'b1;
         src_r   <= clk_source_select_in;
         iface_r <= iface_nxt;
      end
   end

   assign cfg.valid        = valid_r;
   assign cfg.src_external = src_r;
   assign cfg.iface        = iface_r;

   // once captured the selection never moves
   chk_cfg_frozen: assert property (@(posedge clk_in) disable iff (reset_in)
      $past(valid_r) |-> ($stable(iface_r) && $stable(src_r)))
      else $error("configuration changed after capture");
endmodule : strap_latch

//--- design/shared_reference_clock_source_and_iface_select.sv
// shared_reference_clock_source_and_iface_select: picks the clock generator source and drives or
// accepts the shared reference clock pin according to latched straps
// assumes crystal_in and the reference clock input are already sampled at clk_in;
// the 125 MHz output is a rate request to the analog generator, not a digital toggle
//
// reset walk: the first edge after release captures the straps and raises
// cfg_valid_out; the second edge loads direction, rate, mode and generator source,
// and the 50 MHz toggle starts on that same edge, flipping every core cycle
// limitation: straps that move after capture are ignored without any indication,
// only a fresh reset re-arms the capture
// trade-off: 125 MHz exists only as a rate code, since it cannot be drawn on the
// 100 MHz grid; the pin data then stays low while the driver is on
//
// Functional notes
// - the upper select strap low means serial MII family, high means reduced MII.
// - with the source strap low the clock generator runs from the crystal input.
// - crystal source with reduced MII drives the reference pin out at 50 MHz.
// - crystal source with serial MII drives the reference pin out at 125 MHz.
// - with the source strap high the reference pin is an input feeding the generator.
// - the two select straps (upper, lower) are latched after reset release: 00 SMII, 01 SS_SMII, 1x RMII.
`timescale 1ns/100ps
module shared_reference_clock_source_and_iface_select (
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic       iface_select_hi_in,
   input  wire logic       iface_select_lo_in,
   input  wire logic       clk_source_select_in,
   input  wire logic       crystal_in,
   output logic            crystal_out,
   input  wire logic       shared_reference_clock_in,
   output logic            shared_reference_clock_out,
   output logic            shared_reference_clock_oe_out,
   output logic            gen_source_out,
   output logic            gen_from_crystal_out,
   output logic [1:0]      ref_rate_out,
   output logic [1:0]      iface_mode_out,
   output logic            cfg_valid_out
);
   shared_reference_clock_cfg_if cfg_bus ();

   strap_latch u_latch (
      .clk_in               (clk_in),
      .reset_in             (reset_in),
      .iface_select_hi_in   (iface_select_hi_in),
      .iface_select_lo_in   (iface_select_lo_in),
      .clk_source_select_in (clk_source_select_in),
      .cfg                  (cfg_bus.latch)
   );

   // source and direction decode from frozen configuration
   wire use_crystal = cfg_bus.valid && (cfg_bus.src_external == shared_reference_clock_pkg::SRC_CRYSTAL);
   wire use_ext     = cfg_bus.valid && (cfg_bus.src_external == shared_reference_clock_pkg::SRC_EXTERNAL);
   wire is_rmii     = (cfg_bus.iface == shared_reference_clock_pkg::IFACE_RMII);
   wire drive_pin   = use_crystal;
   wire gen_src_nxt = use_ext ? shared_reference_clock_in : crystal_in;
   shared_reference_clock_pkg::rate_t rate_nxt;
   assign rate_nxt = !cfg_bus.valid ? shared_reference_clock_pkg::RATE_NONE
                   : is_rmii        ? shared_reference_clock_pkg::RATE_50M
                                    : shared_reference_clock_pkg::RATE_125M;

   // 50 MHz model clock toggler; 125 MHz is left to the generator
   logic [1:0] half_cnt_r;
   logic [1:0] half_cnt_nxt;
   logic       ref_tgl_r;
   wire        half_done = (half_cnt_r + 2'h1 >= shared_reference_clock_pkg::HALF_CYC);
   assign half_cnt_nxt = half_done ? 2'h0 : half_cnt_r + 2'h1;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         half_cnt_r <= 2'h0;
         ref_tgl_r  <= 1'b0;
      end else if (drive_pin && is_rmii) begin
         half_cnt_r <= half_cnt_nxt;
         if (half_done)
            ref_tgl_r <= ~ref_tgl_r;
      end else begin
         half_cnt_r <= 2'h0;
         ref_tgl_r  <= 1'b0;
      end
   end

   // registered outputs; pin stays undriven until configuration is valid
   logic       oe_r;
   logic       gen_src_r;
   logic       gen_xtal_r;
   logic [1:0] rate_r;
   logic [1:0] mode_r;
   logic       xo_r;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         oe_r       <= 1'b0;
         gen_src_r  <= 1'b0;
         gen_xtal_r <= 1'b0;
         rate_r     <= shared_reference_clock_pkg::RATE_NONE;
         mode_r     <= shared_reference_clock_pkg::IFACE_SMII;
         xo_r       <= 1'b0;
      end else begin
         oe_r       <= drive_pin;
         gen_src_r  <= gen_src_nxt;
         gen_xtal_r <= use_crystal;
         rate_r     <= rate_nxt;
         mode_r     <= cfg_bus.iface;
         xo_r       <= use_crystal ? ~crystal_in : 1'b0;
      end
   end

   assign shared_reference_clock_oe_out = oe_r;
   assign shared_reference_clock_out    = ref_tgl_r;
   assign gen_source_out                = gen_src_r;
   assign gen_from_crystal_out          = gen_xtal_r;
   assign ref_rate_out                  = rate_r;
   assign iface_mode_out                = mode_r;
   assign crystal_out                   = xo_r;
   assign cfg_valid_out                 = cfg_bus.valid;

   // pin driven exactly while the crystal feeds the generator
   chk_pin_direction: assert property (@(posedge clk_in) disable iff (reset_in)
      cfg_bus.valid |=> (oe_r == !$past(cfg_bus.src_external)))
      else $error("reference pin direction wrong");

   // external source: driver off and pin data held low
   chk_ext_pin_input: assert property (@(posedge clk_in) disable iff (reset_in)
      use_ext |=> (!oe_r && !ref_tgl_r))
      else $error("reference pin driven with external source");

   // nothing driven or advertised before capture, so a board
   // clock on the pin never fights the driver during power-up
   chk_idle_before_cfg: assert property (@(posedge clk_in) disable iff (reset_in)
      !cfg_bus.valid |=> (!oe_r && rate_r == shared_reference_clock_pkg::RATE_NONE))
      else $error("output active before capture");

   // reduced family asks for 50 MHz
   chk_rmii_rate: assert property (@(posedge clk_in) disable iff (reset_in)
      (cfg_bus.valid && is_rmii) |=> (rate_r == shared_reference_clock_pkg::RATE_50M))
      else $error("rmii rate wrong");

   // serial family asks for 125 MHz
   chk_serial_rate: assert property (@(posedge clk_in) disable iff (reset_in)
      (cfg_bus.valid && !is_rmii) |=> (rate_r == shared_reference_clock_pkg::RATE_125M))
      else $error("serial rate wrong");

   // crystal with reduced family: driver on
   chk_rmii_pin_on: assert property (@(posedge clk_in) disable iff (reset_in)
      (use_crystal && is_rmii) |=> oe_r)
      else $error("rmii reference pin not driven");

   // crystal with serial family: driver on, data left to the generator
   chk_serial_pin_low: assert property (@(posedge clk_in) disable iff (reset_in)
      (use_crystal && !is_rmii) |=> (oe_r && !ref_tgl_r))
      else $error("serial reference pin wrong");

   // two RMII driving cycles in a row must show two different levels;
   // a stuck toggle would leave the switch without its clock
   chk_rmii_toggle: assert property (@(posedge clk_in) disable iff (reset_in)
      (drive_pin && is_rmii) ##1 (drive_pin && is_rmii)
      |-> (ref_tgl_r != $past(ref_tgl_r)))
      else $error("50 MHz reference not toggling");

   // generator fed by the crystal input
   chk_crystal_source: assert property (@(posedge clk_in) disable iff (reset_in)
      use_crystal |=> (gen_xtal_r && gen_src_r == $past(crystal_in)))
      else $error("generator not fed by crystal");

   // generator fed by the reference pin
   chk_ext_source: assert property (@(posedge clk_in) disable iff (reset_in)
      use_ext |=> (!gen_xtal_r && gen_src_r == $past(shared_reference_clock_in)))
      else $error("generator not fed by reference pin");

   // crystal output inverts the input while the crystal is in use
   chk_xo_crystal: assert property (@(posedge clk_in) disable iff (reset_in)
      use_crystal |=> (xo_r == !$past(crystal_in)))
      else $error("crystal output not inverting input");

   // crystal output parked low with the external source
   chk_xo_quiet: assert property (@(posedge clk_in) disable iff (reset_in)
      use_ext |=> !xo_r)
      else $error("crystal output active with external source");

   // first valid cycle: family bit follows the upper strap seen at capture,
   // not whatever the strap shows later
   chk_capture_hi: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(cfg_bus.valid) |=> (mode_r[1] == $past(iface_select_hi_in, 2)))
      else $error("family code differs from captured strap");

   // lower strap only splits the serial family
   chk_capture_lo: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(cfg_bus.valid) |=>
      (mode_r[0] == (!$past(iface_select_hi_in, 2) && $past(iface_select_lo_in, 2))))
      else $error("variant code differs from captured strap");

   // source follows the source strap seen at capture
   chk_capture_src: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(cfg_bus.valid) |=> (gen_xtal_r == !$past(clk_source_select_in, 2)))
      else $error("source differs from captured strap");

   // capture is never undone without reset
   chk_valid_hold: assert property (@(posedge clk_in) disable iff (reset_in)
      cfg_bus.valid |=> cfg_bus.valid)
      else $error("configuration valid dropped");

   // the unused interface code never appears
   chk_mode_legal: assert property (@(posedge clk_in) disable iff (reset_in)
      cfg_bus.valid |-> (cfg_bus.iface != 2'h3))
      else $error("illegal interface code");

   // rate and mode always describe the same family
   chk_rate_pairs_mode: assert property (@(posedge clk_in) disable iff (reset_in)
      $past(cfg_bus.valid, 2) |->
      ((rate_r == shared_reference_clock_pkg::RATE_50M) == (mode_r == shared_reference_clock_pkg::IFACE_RMII)))
      else $error("rate and mode disagree");

   // once loaded mode, driver enable and rate stay put; strap
   // movement after capture must not leak through
   chk_mode_stable: assert property (@(posedge clk_in) disable iff (reset_in)
      $past(cfg_bus.valid, 2) |-> ($stable(mode_r) && $stable(oe_r) && $stable(rate_r)))
      else $error("mode changed in operation");
endmodule : shared_reference_clock_source_and_iface_select

//--- tb/shared_reference_clock_far_side.sv
// shared_reference_clock_far_side: crystal or oscillator plus the switch sharing the reference pin
// assumes board_ext_in is the board's strap wiring, not the device's latch
`timescale 1ns/100ps
module shared_reference_clock_far_side (
   input  wire logic clk_in,
   input  wire logic board_ext_in,
   input  wire logic oe_in,
   input  wire logic dev_ref_in,
   output logic      xtal_out,
   output logic      pin_out
);
   logic [1:0] ph_r = 2'h0;
   logic       ext_r = 1'b0;
   // 125 MHz cannot exist on a 100 MHz grid, so both rates toggle per cycle
   always @(posedge clk_in) begin
      ph_r  <= ph_r + 2'h1;
      ext_r <= ~ext_r;
   end
   // an open crystal input shows a changing pattern, never a held value
   assign xtal_out = board_ext_in ? ~ph_r[0] : ph_r[1];
   assign pin_out  = oe_in ? dev_ref_in : ext_r;
endmodule : shared_reference_clock_far_side

//--- tb/tb_shared_reference_clock_source_and_iface_select.sv
// tb_shared_reference_clock_source_and_iface_select: sweeps every strap code, then shakes straps
// assumes the far-side model feeds crystal and reference pin
`timescale 1ns/100ps
module tb_shared_reference_clock_source_and_iface_select;
   logic       clk_in = 1'b0, reset_r = 1'b1, hi = 1'b0, lo = 1'b0, src = 1'b0, brd = 1'b0;
   wire        xtal, pin;
   logic       xout, rout, oe, gsrc, gxt, cv, xq, pq, rq;
   logic [1:0] rate, mode;
   int         err_total = 0, comparisons = 0, cycles = 0, seed = 82, i;
   always #5 clk_in = ~clk_in;
   shared_reference_clock_source_and_iface_select dut (.clk_in(clk_in), .reset_in(reset_r),
      .iface_select_hi_in(hi), .iface_select_lo_in(lo), .clk_source_select_in(src),
      .crystal_in(xtal), .crystal_out(xout), .shared_reference_clock_in(pin),
      .shared_reference_clock_out(rout), .shared_reference_clock_oe_out(oe),
      .gen_source_out(gsrc), .gen_from_crystal_out(gxt), .ref_rate_out(rate),
      .iface_mode_out(mode), .cfg_valid_out(cv));
   shared_reference_clock_far_side far (.clk_in(clk_in), .board_ext_in(brd), .oe_in(oe),
      .dev_ref_in(rout), .xtal_out(xtal), .pin_out(pin));
   task finish_test();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   // hang guard, generous for twelve short configurations
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 1000) begin
         err_total++;
         finish_test();
      end
   end
   task chk(input string name, input logic [1:0] exp, input logic [1:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // expected codes straight from the strap rules
   function automatic logic [1:0] exp_mode(input logic h, input logic l);
      return h ? 2'h2 : {1'b0, l};
   endfunction : exp_mode
   function automatic logic [1:0] exp_rate(input logic h);
      return h ? 2'h1 : 2'h2;
   endfunction : exp_rate
   // one reset and capture, then straps wander while mode, enable and rate must hold
   task run_cfg(input logic h, input logic l, input logic s);
      int k;
      @(posedge clk_in);
      reset_r <= 1'b1;
      hi <= h;
      lo <= l;
      src <= s;
      brd <= s;
      @(negedge clk_in);
      chk("reset_outputs", 2'h0, {oe, cv});
      chk("reset_rate", 2'h0, rate);
      chk("reset_mode", 2'h0, mode);
      @(posedge clk_in);
      reset_r <= 1'b0;
      // first edge after release is the capture edge
      @(posedge clk_in);
      @(negedge clk_in);
      chk("cfg_valid", 2'h1, {oe, cv});
      xq = xtal;
      pq = pin;
      rq = rout;
      for (k = 0; k < 12; k++) begin
         @(posedge clk_in);
         if (k > 1) begin
            hi <= 1'($random(seed));
            lo <= 1'($random(seed));
            src <= 1'($random(seed));
         end
         @(negedge clk_in);
         chk("mode", exp_mode(h, l), mode);
         chk("oe_gen", {~s, ~s}, {oe, gxt});
         chk("rate", exp_rate(h), rate);
         chk("gen_source", {1'b0, s ? pq : xq}, {1'b0, gsrc});
         chk("crystal_out", {1'b0, ~s & ~xq}, {1'b0, xout});
         chk("ref_out", {1'b0, (!s && h) ? ~rq : 1'b0}, {1'b0, rout});
         xq = xtal;
         pq = pin;
         rq = rout;
      end
   endtask : run_cfg
   initial begin
      repeat (5) @(posedge clk_in);
      reset_r <= 1'b0;
      for (i = 0; i < 8; i++) run_cfg(i[2], i[1], i[0]);
      // a few random codes on top of the full sweep
      repeat (4) run_cfg(1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
      finish_test();
   end
endmodule : tb_shared_reference_clock_source_and_iface_select
